// ===== rtl/acc_amp_control.sv
// Amplifier control configuration fields with idle-input auto-sleep
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Contract
// - A two-bit sleep field turns the power stage off after 1024, 64x1024 or 256x1024 idle frames, 00 disables it.
// - The slot-width bit selects 24/32-bit slots when zero and 16-bit slots when one.
// - The clock-source bit takes the master clock from the bit clock when zero and from its pin when one.
// - Bit 0 of the audio input control register is the volume least significant bit.
// - The pull-up bit enables the internal pull-up on the active-low fault pin.
// - The regulator bit selects the reduced analog regulator level when one.
// - The current-trim bit lowers static analog supply current when set.
// - The PWM rate field at 0x06 bits 6-4 resets to code 101.
// - The analog gain field sits at 0x06 bits 3-2 with its documented default.
module acc_amp_control (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  input  wire logic                frame_pulse,
  input  wire logic                sample_nonzero,
  input  wire logic                bclk_div_clk,
  input  wire logic                mclk_pin,
  output logic                     master_clk_sel,
  output logic                     power_stage_enable,
  output logic                     volume_level_lsb,
  output acc_pkg::acc_ctrl_t       ctrl
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  audio_ctl_r;
  logic [7:0]  trim_ctl_r;
  logic [7:0]  pwm_gain_r;
  logic [7:0]  rdata_r;
  logic [18:0] idle_cnt_r;
  logic [18:0] idle_cnt_nxt;
  logic        asleep_r;
  logic        asleep_nxt;
  logic [1:0]  sleep_prev_r;

  // Decode of the plain register port
  wire hit_audio = reg_addr == acc_pkg::AUDIO_INPUT_CONTROL_OFS;
  wire hit_trim  = reg_addr == acc_pkg::ANALOG_TRIM_CONTROL_OFS;
  wire hit_pwm   = reg_addr == acc_pkg::PWM_GAIN_CONTROL_OFS;
  wire wr_audio  = reg_wr && hit_audio;
  wire wr_trim   = reg_wr && hit_trim;
  wire wr_pwm    = reg_wr && hit_pwm;

  // Unmapped addresses read as zero
  wire [7:0] rd_mux = hit_audio ? audio_ctl_r :
                      hit_trim  ? trim_ctl_r  :
                      hit_pwm   ? pwm_gain_r  : 8'h00;

  // Register writes; reserved trim bits are stored as written, host keeps them legal
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      audio_ctl_r <= acc_pkg::AUDIO_INPUT_CONTROL_RST;
      trim_ctl_r  <= acc_pkg::ANALOG_TRIM_CONTROL_RST;
      pwm_gain_r  <= acc_pkg::PWM_GAIN_CONTROL_RST;
    end else begin
      if (wr_audio) audio_ctl_r <= reg_wdata;
      if (wr_trim)  trim_ctl_r  <= reg_wdata;
      if (wr_pwm)   pwm_gain_r  <= reg_wdata;
    end
  end

  // Read data lands the cycle after the strobe and only then
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) rdata_r <= 8'h00;
    else       rdata_r <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  wire [1:0] sleep_code = audio_ctl_r[acc_pkg::SLEEP_LSB +: 2];

  assign ctrl.narrow_slot_select      = audio_ctl_r[acc_pkg::SLOT_BIT];
  assign ctrl.mclk_from_pin           = audio_ctl_r[acc_pkg::CLKSRC_BIT];
  assign ctrl.fault_pin_pullup_enable = trim_ctl_r[acc_pkg::PULLUP_BIT];
  assign ctrl.regulator_level_select  = trim_ctl_r[acc_pkg::VREG_BIT];
  assign ctrl.analog_current_trim     = trim_ctl_r[acc_pkg::CURTRIM_BIT];
  assign ctrl.pwm_rate    = pwm_gain_r[acc_pkg::PWM_RATE_LSB +: 3];
  assign ctrl.analog_gain = pwm_gain_r[acc_pkg::GAIN_LSB +: 2];
  assign volume_level_lsb = audio_ctl_r[acc_pkg::VOL_LSB_BIT];

  // Clock source select only; the clock mux itself lives in the clock tree
  assign master_clk_sel = audio_ctl_r[acc_pkg::CLKSRC_BIT];

  // ----------------------------------------------------------------
  // Idle-input auto sleep
  // ----------------------------------------------------------------
  // Timeout per code; OFF yields zero, which any count meets, so reached is gated by sleep_on
  wire [18:0] limit = (sleep_code == acc_pkg::ACC_SLEEP_1K)  ? acc_pkg::SLEEP_FRAMES_1K  :
                      (sleep_code == acc_pkg::ACC_SLEEP_64K) ? acc_pkg::SLEEP_FRAMES_64K :
                      (sleep_code == acc_pkg::ACC_SLEEP_256K) ? acc_pkg::SLEEP_FRAMES_256K :
                      19'h00000;
  wire sleep_on   = sleep_code != acc_pkg::ACC_SLEEP_OFF;
  wire code_moved = sleep_code != sleep_prev_r;
  wire idle_frame = frame_pulse && !sample_nonzero;
  wire reached    = sleep_on && idle_frame && (idle_cnt_r + 19'h00001 >= limit);

  // Counter saturates at the limit; any activity or code change restarts it
  always_comb begin
    idle_cnt_nxt = idle_cnt_r;
    asleep_nxt   = asleep_r;
    if (code_moved || !sleep_on) begin
      idle_cnt_nxt = 19'h00000;
      asleep_nxt   = 1'b0;
    end else if (frame_pulse && sample_nonzero) begin
      idle_cnt_nxt = 19'h00000;
      asleep_nxt   = 1'b0;
    end else if (reached) begin
      idle_cnt_nxt = limit;
      asleep_nxt   = 1'b1;
    end else if (idle_frame) begin
      idle_cnt_nxt = idle_cnt_r + 19'h00001;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idle_cnt_r   <= 19'h00000;
      asleep_r     <= 1'b0;
      sleep_prev_r <= 2'h0;
    end else begin
      idle_cnt_r   <= idle_cnt_nxt;
      asleep_r     <= asleep_nxt;
      sleep_prev_r <= sleep_code;
    end
  end

  // Power stage is held off while asleep
  assign power_stage_enable = !asleep_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Marks the first edge after any reset, so defaults are seen before a write can land
  logic first_cycle_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) first_cycle_r <= 1'b1;
    else       first_cycle_r <= 1'b0;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_wr_trim;
    reg_wr && hit_trim;
  endsequence

  // Write strobes per register, qualified by the decoded address
  sequence s_wr_audio;
    reg_wr && hit_audio;
  endsequence

  sequence s_wr_pwm;
    reg_wr && hit_pwm;
  endsequence

  // Frame events as the idle counter sees them
  sequence s_idle_frame;
    frame_pulse && !sample_nonzero;
  endsequence

  sequence s_live_frame;
    frame_pulse && sample_nonzero;
  endsequence

  // A sleep entry is an idle frame that reaches the limit with the code unchanged
  sequence s_sleep_entry;
    reached && !code_moved;
  endsequence

  rdata_late_a: assert property (reg_rd |=> reg_rdata == $past(rd_mux))
    else $error("read data not presented one cycle after strobe");
  rdata_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  sleep_off_a: assert property (!sleep_on |=> power_stage_enable)
    else $error("power stage off with auto sleep disabled");
  wake_sample_a: assert property (frame_pulse && sample_nonzero |=> power_stage_enable)
    else $error("nonzero sample did not wake power stage");
  code_restart_a: assert property (code_moved |=> idle_cnt_r == 19'h00000)
    else $error("idle counter not restarted on code change");
  sleep_hit_a: assert property (reached && !code_moved |=> !power_stage_enable)
    else $error("power stage not disabled at timeout");
  trim_write_a: assert property (s_wr_trim |=> trim_ctl_r == $past(reg_wdata))
    else $error("trim register write lost");

  // ----------------------------------------------------------------
  // Reset defaults, seen at the first edge after release
  // ----------------------------------------------------------------
  // Default PWM rate code
  pwm_default_a: assert property (first_cycle_r |->
    ctrl.pwm_rate == acc_pkg::PWM_RATE_RST)
    else $error("pwm rate not at default after reset");

  // Default analog gain code
  gain_default_a: assert property (first_cycle_r |->
    ctrl.analog_gain == acc_pkg::ANALOG_GAIN_RST)
    else $error("analog gain not at default after reset");

  // Trim register comes up with its reserved one set
  trim_default_a: assert property (first_cycle_r |->
    trim_ctl_r == acc_pkg::ANALOG_TRIM_CONTROL_RST)
    else $error("trim register not at default after reset");

  // Audio control comes up with auto sleep off
  audio_default_a: assert property (first_cycle_r |->
    audio_ctl_r == acc_pkg::AUDIO_INPUT_CONTROL_RST)
    else $error("audio control not at default after reset");

  // Power stage runs straight out of reset
  awake_reset_a: assert property (first_cycle_r |-> power_stage_enable)
    else $error("power stage off after reset");

  // ----------------------------------------------------------------
  // Field writes reach their outputs one cycle later
  // ----------------------------------------------------------------
  // Slot width follows the written bit
  slot_sel_a: assert property (s_wr_audio |=>
    ctrl.narrow_slot_select == $past(reg_wdata[acc_pkg::SLOT_BIT]))
    else $error("slot width select mismatch");

  // Clock source select follows the written bit
  clk_src_a: assert property (s_wr_audio |=>
    master_clk_sel == $past(reg_wdata[acc_pkg::CLKSRC_BIT]))
    else $error("clock source select mismatch");

  // Both copies of the clock source agree
  clk_pin_a: assert property (master_clk_sel == ctrl.mclk_from_pin)
    else $error("clock source copies disagree");

  // Volume low bit follows the written bit
  vol_lsb_a: assert property (s_wr_audio |=>
    volume_level_lsb == $past(reg_wdata[acc_pkg::VOL_LSB_BIT]))
    else $error("volume low bit mismatch");

  // Fault pin pull-up follows the written bit
  pullup_sel_a: assert property (s_wr_trim |=>
    ctrl.fault_pin_pullup_enable == $past(reg_wdata[acc_pkg::PULLUP_BIT]))
    else $error("pull-up enable mismatch");

  // Regulator level follows the written bit
  vreg_sel_a: assert property (s_wr_trim |=>
    ctrl.regulator_level_select == $past(reg_wdata[acc_pkg::VREG_BIT]))
    else $error("regulator level mismatch");

  // Current trim follows the written bit
  cur_trim_a: assert property (s_wr_trim |=>
    ctrl.analog_current_trim == $past(reg_wdata[acc_pkg::CURTRIM_BIT]))
    else $error("current trim mismatch");

  // PWM rate field follows the written bits
  pwm_write_a: assert property (s_wr_pwm |=>
    ctrl.pwm_rate == $past(reg_wdata[acc_pkg::PWM_RATE_LSB +: 3]))
    else $error("pwm rate write lost");

  // Analog gain field follows the written bits
  gain_write_a: assert property (s_wr_pwm |=>
    ctrl.analog_gain == $past(reg_wdata[acc_pkg::GAIN_LSB +: 2]))
    else $error("analog gain write lost");

  // Registers hold between their writes
  audio_hold_a: assert property (!wr_audio |=> $stable(audio_ctl_r))
    else $error("audio control changed without a write");

  trim_hold_a: assert property (!wr_trim |=> $stable(trim_ctl_r))
    else $error("trim register changed without a write");

  pwm_hold_a: assert property (!wr_pwm |=> $stable(pwm_gain_r))
    else $error("pwm register changed without a write");

  // Writes to unmapped places leave every register alone
  wr_unmap_a: assert property (reg_wr && !hit_audio && !hit_trim && !hit_pwm |=>
    $stable(audio_ctl_r) && $stable(trim_ctl_r) && $stable(pwm_gain_r))
    else $error("unmapped write changed a register");

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Each register reads back as it stood at the strobe
  rd_audio_a: assert property (reg_rd && hit_audio |=>
    reg_rdata == $past(audio_ctl_r))
    else $error("audio control read mismatch");

  rd_trim_a: assert property (reg_rd && hit_trim |=>
    reg_rdata == $past(trim_ctl_r))
    else $error("trim register read mismatch");

  rd_pwm_a: assert property (reg_rd && hit_pwm |=>
    reg_rdata == $past(pwm_gain_r))
    else $error("pwm register read mismatch");

  // Unmapped reads return zero
  rd_unmap_a: assert property (reg_rd && !hit_audio && !hit_trim && !hit_pwm |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // Idle counter and sleep state
  // ----------------------------------------------------------------
  // Timeout per code
  short_limit_a: assert property (sleep_code == acc_pkg::ACC_SLEEP_1K |->
    limit == 19'h00400)
    else $error("wrong short timeout");

  mid_limit_a: assert property (sleep_code == acc_pkg::ACC_SLEEP_64K |->
    limit == 19'h10000)
    else $error("wrong middle timeout");

  long_limit_a: assert property (sleep_code == acc_pkg::ACC_SLEEP_256K |->
    limit == 19'h40000)
    else $error("wrong long timeout");

  // Counter never runs past its limit once the code has settled
  cnt_limit_a: assert property (sleep_on && !code_moved |-> idle_cnt_r <= limit)
    else $error("idle counter above limit");

  // Disabled feature keeps the counter at zero
  cnt_off_a: assert property (!sleep_on |=> idle_cnt_r == 19'h00000)
    else $error("idle counter runs with auto sleep off");

  // A nonzero sample clears the count
  live_clear_a: assert property (s_live_frame |=> idle_cnt_r == 19'h00000)
    else $error("idle counter not cleared by audio");

  // Each idle frame below the limit adds exactly one
  idle_step_a: assert property (frame_pulse && !sample_nonzero && sleep_on &&
    !code_moved && !reached |=> idle_cnt_r == $past(idle_cnt_r) + 19'h00001)
    else $error("idle counter step wrong");

  // Without a frame nothing moves
  quiet_hold_a: assert property (!frame_pulse && sleep_on && !code_moved |=>
    $stable(idle_cnt_r) && $stable(asleep_r))
    else $error("sleep state moved without a frame");

  // Entry saturates the count at the limit
  sleep_entry_a: assert property (s_sleep_entry |=> idle_cnt_r == $past(limit))
    else $error("idle counter not saturated at sleep entry");

  // Sleep is only entered at the limit
  no_early_a: assert property (power_stage_enable && !reached |=>
    power_stage_enable)
    else $error("power stage off before timeout");

  // Sleep holds while nothing wakes it
  sleep_stay_a: assert property (!power_stage_enable && !frame_pulse &&
    !code_moved && sleep_on |=> !power_stage_enable)
    else $error("power stage woke without cause");

  // Idle frames never wake the stage
  idle_stay_a: assert property (s_idle_frame ##0 !power_stage_enable ##0
    !code_moved ##0 sleep_on |=> !power_stage_enable)
    else $error("idle frame woke power stage");

  // A code change wakes the stage
  wake_code_a: assert property (code_moved |=> power_stage_enable)
    else $error("code change did not wake power stage");

  // The previous code tracks the field every cycle
  prev_track_a: assert property (1'b1 |=> sleep_prev_r == $past(sleep_code))
    else $error("previous sleep code not tracked");

endmodule

// ===== rtl/acc_pkg.sv
// Package: register map, field layout, reset values and timing counts for amp control fields
package acc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] AUDIO_INPUT_CONTROL_OFS = 8'h13;
  localparam logic [7:0] ANALOG_TRIM_CONTROL_OFS = 8'h14;
  localparam logic [7:0] PWM_GAIN_CONTROL_OFS    = 8'h06;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLEEP_LSB      = 3;
  localparam int SLOT_BIT       = 2;
  localparam int CLKSRC_BIT     = 1;
  localparam int VOL_LSB_BIT    = 0;
  localparam int PULLUP_BIT     = 3;
  localparam int VREG_BIT       = 2;
  localparam int TRIM_RSV1_BIT  = 1;
  localparam int CURTRIM_BIT    = 0;
  localparam int PWM_RATE_LSB   = 4;
  localparam int GAIN_LSB       = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AUDIO_INPUT_CONTROL_RST = 8'h00;
  localparam logic [7:0] ANALOG_TRIM_CONTROL_RST = 8'h02;
  localparam logic [2:0] PWM_RATE_RST            = 3'h5;
  localparam logic [1:0] ANALOG_GAIN_RST         = 2'h0;
  localparam logic [7:0] PWM_GAIN_CONTROL_RST    =
    {1'b0, PWM_RATE_RST, ANALOG_GAIN_RST, 2'b00};
  localparam logic [7:0] ANALOG_TRIM_WR_MASK     = 8'h0f;

  // ----------------------------------------------------------------
  // Sleep timeout codes and frame counts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_SLEEP_OFF  = 2'h0,
    ACC_SLEEP_1K   = 2'h1,
    ACC_SLEEP_64K  = 2'h2,
    ACC_SLEEP_256K = 2'h3
  } acc_sleep_t;

  localparam int          FRAME_UNIT       = 1024;
  localparam logic [18:0] SLEEP_FRAMES_1K  = 19'(FRAME_UNIT);
  localparam logic [18:0] SLEEP_FRAMES_64K = 19'(64 * FRAME_UNIT);
  localparam logic [18:0] SLEEP_FRAMES_256K = 19'(256 * FRAME_UNIT);

  // ----------------------------------------------------------------
  // Carrier of the analog and clocking controls
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       narrow_slot_select;
    logic       mclk_from_pin;
    logic       fault_pin_pullup_enable;
    logic       regulator_level_select;
    logic       analog_current_trim;
    logic [2:0] pwm_rate;
    logic [1:0] analog_gain;
  } acc_ctrl_t;

endpackage

// ===== verification/acc_host_model.sv
// Host controller model that drives the plain register port
`timescale 1ns/1ps
module acc_host_model (
  input  wire logic       ref_clk,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus from time zero so reset never sees a floating strobe
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe launched just after an edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Trim writes always carry legal reserved bits, whatever the caller asks
  task automatic write_trim(input logic [7:0] d);
    write_reg(acc_pkg::ANALOG_TRIM_CONTROL_OFS, {4'h0, d[3:2], 1'b1, d[0]});
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
endmodule

// ===== verification/acc_amp_control_tb.sv
// Self-checking bench for the amplifier control fields
`timescale 1ns/1ps
module acc_amp_control_tb;
  logic               ref_clk = 1'b0;
  logic               reset = 1'b1;
  logic               frame_pulse = 1'b0;
  logic               sample_nonzero = 1'b0;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata, q, d;
  logic               reg_wr, reg_rd, master_clk_sel, power_stage_enable, volume_level_lsb;
  acc_pkg::acc_ctrl_t ctrl;
  int                 bad_count, tests_run, cyc;
  int                 mdl [int];
  logic [31:0]        seed = 32'd80678;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  acc_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  acc_amp_control dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_pulse(frame_pulse), .sample_nonzero(sample_nonzero), .bclk_div_clk(1'b0),
    .mclk_pin(1'b0), .master_clk_sel(master_clk_sel), .power_stage_enable(power_stage_enable),
    .volume_level_lsb(volume_level_lsb), .ctrl(ctrl));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Unmapped places read as zero in the model
  task automatic rd_chk(input logic [7:0] a);
    host_u.read_reg(a, q);
    check("rdata", q, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
  endtask

  task automatic wr13(input logic [7:0] v);
    host_u.write_reg(acc_pkg::AUDIO_INPUT_CONTROL_OFS, v);
    mdl[8'h13] = v;
  endtask

  // Two cycles per frame, then let the registered output settle
  task automatic frames(input int n, input logic nz);
    repeat (n) begin
      @(posedge ref_clk);
      frame_pulse    <= 1'b1;
      sample_nonzero <= nz;
      @(posedge ref_clk);
      frame_pulse    <= 1'b0;
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, well above the expected run of about 12600 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mdl[8'h13] = 8'h00;
    mdl[8'h14] = 8'h02;
    mdl[8'h06] = 8'h50;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(8'h13);
    rd_chk(8'h14);
    rd_chk(8'h06);
    rd_chk(8'h20);
    check("pwm_rate", 8'(ctrl.pwm_rate), 8'h05);
    check("gain_field", 8'(ctrl.analog_gain), 8'h00);
    $display("Test reset values done");
    // Random traffic with a junk write to an unmapped place in between
    for (int i = 0; i < 8; i++) begin
      wr13(rnd());
      d = rnd();
      host_u.write_trim(d);
      mdl[8'h14] = {4'h0, d[3:2], 1'b1, d[0]};
      host_u.write_reg(8'h21, rnd());
      d = rnd();
      host_u.write_reg(acc_pkg::PWM_GAIN_CONTROL_OFS, d);
      mdl[8'h06] = d;
      rd_chk(8'h21);
      rd_chk(8'h06);
      check("pwm_wr", 8'(ctrl.pwm_rate), 8'(d[6:4]));
      check("gain_wr", 8'(ctrl.analog_gain), 8'(d[3:2]));
      rd_chk(8'h13);
      rd_chk(8'h14);
      d = 8'(mdl[8'h13]);
      check("slot", 8'(ctrl.narrow_slot_select), 8'(d[2]));
      check("clk_sel", 8'(master_clk_sel), 8'(d[1]));
      check("clk_pin", 8'(ctrl.mclk_from_pin), 8'(d[1]));
      check("vol_lsb", 8'(volume_level_lsb), 8'(d[0]));
      d = 8'(mdl[8'h14]);
      check("pullup", 8'(ctrl.fault_pin_pullup_enable), 8'(d[3]));
      check("vreg", 8'(ctrl.regulator_level_select), 8'(d[2]));
      check("trim", 8'(ctrl.analog_current_trim), 8'(d[0]));
    end
    $display("Test field mapping done");
    // Auto sleep: exact count, clear on audio, restart on code change
    wr13(8'h08);
    frames(1023, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h01);
    frames(1, 1'b1);
    frames(1023, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h01);
    frames(1, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h00);
    frames(1, 1'b1);
    check("pse", 8'(power_stage_enable), 8'h01);
    frames(1000, 1'b0);
    wr13(8'h18);
    wr13(8'h08);
    frames(1000, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h01);
    frames(24, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h00);
    wr13(8'h10);
    frames(1100, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h01);
    wr13(8'h00);
    frames(2, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h01);
    $display("Test auto sleep done");
    // Reset in mid-run while asleep must restore defaults and wake the stage
    wr13(8'h0f);
    frames(1024, 1'b0);
    check("pse", 8'(power_stage_enable), 8'h00);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    mdl[8'h13] = 8'h00;
    mdl[8'h14] = 8'h02;
    mdl[8'h06] = 8'h50;
    rd_chk(8'h13);
    rd_chk(8'h14);
    rd_chk(8'h06);
    check("pse", 8'(power_stage_enable), 8'h01);
    $display("Test mid-run reset done");
    end_sim();
  end
endmodule
